/* File: logic/sld_driver_top.sv */
// Serial-in, latched eight-output driver: shift register, latches, blanking
//
// Summary of operation
// - A queued shift clock rising edge captures serial data into the first stage; edges into a full queue are dropped.
// - Each later queued rising edge moves every stage one place toward the cascade output.
// - While strobe is high each latch takes its shift stage value.
// - Latches stay transparent, following new shift values, while strobe stays high.
// - Disable high forces all outputs off; latches and shift stages kept.
// - Disable low drives each output from its own latch.
`timescale 1ns/1ps
module sld_driver_top #(
	parameter int STAGES     = sld_pkg::STAGES,
	parameter int FIFO_DEPTH = sld_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              nrst_in,
	// Serial control pins from the host
	input  wire logic              serial_data_in,
	input  wire logic              shift_clk_in,
	input  wire logic              strobe_in,
	input  wire logic              out_disable_in,
	// Stall of the bit queue drain
	input  wire logic              shift_hold_in,
	// Driver, cascade and shift ready outputs
	output logic [STAGES-1:0]      drive_out,
	output logic                   cascade_out,
	output logic                   shift_ready_out
);
	import sld_pkg::*;

	if (STAGES != 8 || FIFO_DEPTH < 2) begin : g_chk
		$error("sld_driver_top: STAGES must be 8 and FIFO_DEPTH at least 2");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [STAGES-1:0] sreg;
		logic [STAGES-1:0] latch;
		logic [STAGES-1:0] drv;
		logic              casc;
		logic              rdy;
		logic              trk_armed;
		logic [3:0]        trk_hops;
		logic              trk_bit;
	} sld_top_s;

	sld_top_s q;
	sld_top_s next_q;
	logic     shift_rise;
	logic     shift_now;

	sld_stream_if #(.WIDTH(FIFO_WIDTH)) bits ();

	// ------------------------------------------------------------
	// Shift clock edge and bit queue
	// ------------------------------------------------------------
	sld_rise_det u_rise (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.level_in   (shift_clk_in),
		.rise_out   (shift_rise)
	);

	// Each rising shift edge queues the data bit present at it while the queue has room; edges into a full queue are dropped
	assign bits.push_valid = shift_rise;
	assign bits.push_data  = serial_data_in;
	assign bits.pop_ready  = !shift_hold_in;
	assign shift_now       = bits.pop_valid && bits.pop_ready;

	sld_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_in (sys_clk_in),
		.nrst_in    (nrst_in),
		.st         (bits)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_q = q;
		if (shift_now) begin
			next_q.sreg = {q.sreg[STAGES-2:0], bits.pop_data[0]};
		end
		if (strobe_in) begin
			next_q.latch = next_q.sreg;
		end
		next_q.drv  = out_disable_in ? DRIVE_OFF : next_q.latch;
		next_q.casc = next_q.sreg[STAGES-1];
		next_q.rdy  = bits.push_ready;
		// Follow one drained bit down the chain so the checks can find it
		if (shift_now) begin
			if (!q.trk_armed || q.trk_hops == 4'(STAGES - 1)) begin
				next_q.trk_armed = 1'b1;
				next_q.trk_hops  = 4'h0;
				next_q.trk_bit   = bits.pop_data[0];
			end else begin
				next_q.trk_hops  = q.trk_hops + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '{
				sreg:      SREG_RST,
				latch:     LATCH_RST,
				drv:       DRIVE_OFF,
				casc:      1'b0,
				rdy:       1'b0,
				trk_armed: 1'b0,
				trk_hops:  4'h0,
				trk_bit:   1'b0
			};
		end else begin
			q <= next_q;
		end
	end

	assign drive_out       = q.drv;
	assign cascade_out     = q.casc;
	assign shift_ready_out = q.rdy;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	sequence s_shift;
		shift_now;
	endsequence

	sequence s_transparent_shift;
		strobe_in && shift_now ##1 strobe_in && !shift_now;
	endsequence

	sequence s_idle_edge_in;
		shift_rise && bits.push_ready && !bits.pop_valid && !shift_hold_in ##1 !shift_hold_in;
	endsequence

	AST_CAPTURE_FIRST: assert property (
		s_idle_edge_in |=> q.sreg[0] == $past(serial_data_in, 2))
		else $error("Serial bit not captured into first stage");

	AST_SHIFT_ON: assert property (
		s_shift |=> q.sreg[STAGES-1:1] == $past(q.sreg[STAGES-2:0]))
		else $error("Stages did not move toward cascade output");

	AST_LATCH_TAKE: assert property (
		strobe_in |=> q.latch == q.sreg)
		else $error("Latch did not take shift stage value under strobe");

	AST_LATCH_FOLLOW: assert property (
		s_transparent_shift |=> q.latch == q.sreg && q.latch[0] == $past(bits.pop_data[0], 2))
		else $error("Transparent latch did not follow a later shift");

	AST_BLANK: assert property (
		out_disable_in |=> q.drv == DRIVE_OFF)
		else $error("Outputs not off while disabled");

	AST_BLANK_KEEPS: assert property (
		out_disable_in && !strobe_in && !shift_now |=> $stable(q.latch) && $stable(q.sreg))
		else $error("Blanking disturbed stored data");

	AST_DRIVE: assert property (
		!out_disable_in |=> drive_out == q.latch)
		else $error("Output does not follow its latch");

	AST_HOLD: assert property (
		!strobe_in |=> q.latch == $past(q.latch))
		else $error("Latch changed while strobe low");

	AST_CASCADE: assert property (
		!shift_now ##1 !shift_now |=> cascade_out == q.sreg[STAGES-1])
		else $error("Cascade output differs from last stage");

	// ------------------------------------------------------------
	// Further checks on the chain, outputs and queue
	// ------------------------------------------------------------
	sequence s_quiet;
		!strobe_in && !out_disable_in ##1 !strobe_in && !out_disable_in;
	endsequence

	sequence s_track_end;
		q.trk_armed && q.trk_hops == 4'(STAGES - 1);
	endsequence

	sequence s_release;
		$rose(nrst_in);
	endsequence

	sequence s_strobe_low2;
		!strobe_in ##1 !strobe_in;
	endsequence

	sequence s_unblank;
		out_disable_in ##1 !out_disable_in;
	endsequence

	AST_EDGE_QUEUED: assert property (
		shift_rise && bits.push_ready
		|=> bits.pop_valid)
		else $error("Shift clock edge not queued");

	AST_STAGE0_FROM_QUEUE: assert property (
		s_shift
		|=> q.sreg[0] == $past(bits.pop_data[0]))
		else $error("First stage did not take the drained bit");

	AST_CASCADE_SHIFT: assert property (
		s_shift
		|=> cascade_out == $past(q.sreg[STAGES-2]))
		else $error("Cascade output did not take the stage before it");

	AST_NO_SHIFT_KEEPS: assert property (
		!shift_now
		|=> $stable(q.sreg))
		else $error("Stages moved without a shift clock edge");

	AST_TRACK_STAGE: assert property (
		q.trk_armed
		|-> q.sreg[q.trk_hops[2:0]] == q.trk_bit)
		else $error("Tracked bit not found in its stage");

	AST_TRACK_CASCADE: assert property (
		s_track_end
		|-> cascade_out == q.trk_bit)
		else $error("Bit in the eighth stage not on the cascade output");

	AST_DRIVE_ON_STROBE: assert property (
		strobe_in && !out_disable_in
		|=> drive_out == q.sreg)
		else $error("Outputs do not show the stages under strobe");

	AST_BLANK_OUT: assert property (
		out_disable_in
		|=> drive_out == DRIVE_OFF)
		else $error("Output pins on while disabled");

	AST_UNBLANK: assert property (
		s_unblank
		|=> drive_out == q.latch)
		else $error("Outputs did not return to their latches after blanking");

	AST_DRIVE_STABLE: assert property (
		s_quiet
		|=> $stable(drive_out))
		else $error("Outputs changed with strobe and disable low");

	AST_HOLD_TWO: assert property (
		s_strobe_low2
		|=> q.latch == $past(q.latch, 2))
		else $error("Latch drifted over two cycles of strobe low");

	AST_LATCH_ONLY_STROBE: assert property (
		$changed(q.latch)
		|-> $past(strobe_in))
		else $error("Latch changed without strobe");

	AST_RESET_CLEAR: assert property (
		s_release
		|-> q.sreg == SREG_RST && q.latch == LATCH_RST && drive_out == DRIVE_OFF && !cascade_out)
		else $error("State not cleared by reset");

	AST_READY_AFTER_RESET: assert property (
		s_release
		|=> shift_ready_out)
		else $error("Shift ready not raised after reset");

	AST_READY_FULL: assert property (
		!bits.push_ready
		|=> !shift_ready_out)
		else $error("Shift ready high with the queue full");

	AST_STALL: assert property (
		shift_hold_in
		|=> $stable(q.sreg))
		else $error("Stages moved while draining was stalled");

	// ------------------------------------------------------------
	// Per-output checks
	// ------------------------------------------------------------
	for (genvar i = 0; i < STAGES; i++) begin : g_out
		AST_BIT_OFF: assert property (
			out_disable_in
			|=> !drive_out[i])
			else $error("An output stayed on while disabled");

		AST_BIT_FOLLOW: assert property (
			!out_disable_in
			|=> drive_out[i] == q.latch[i])
			else $error("An output differs from its own latch");
	end

endmodule // sld_driver_top

/* File: logic/sld_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sld_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic   sys_clk_in,
	input  wire logic   nrst_in,
	// Stream
	sld_stream_if.queue st
);
	import sld_pkg::*;

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
		$error("sld_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} sld_fifo_s;

	sld_fifo_s q;
	sld_fifo_s next_q;
	logic      do_push;
	logic      do_pop;

	assign st.push_ready = (q.cnt != (AW+1)'(DEPTH));
	assign st.pop_valid  = (q.cnt != '0);
	assign st.pop_data   = q.mem[q.rd];
	assign do_push       = st.push_valid && st.push_ready;
	assign do_pop        = st.pop_valid && st.pop_ready;

	always_comb begin
		next_q = q;
		if (do_push) begin
			next_q.mem[q.wr] = st.push_data;
			next_q.wr        = q.wr + 1'b1;
		end
		if (do_pop) begin
			next_q.rd = q.rd + 1'b1;
		end
		case ({do_push, do_pop})
			2'b10:   next_q.cnt = q.cnt + 1'b1;
			2'b01:   next_q.cnt = q.cnt - 1'b1;
			default: next_q.cnt = q.cnt;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule // sld_fifo

/* File: logic/sld_pkg.sv */
// Constants shared by the serial-in latched driver block
package sld_pkg;

	// ------------------------------------------------------------
	// Structure
	// ------------------------------------------------------------
	localparam int STAGES      = 8;
	localparam int FIFO_DEPTH  = 32;
	localparam int FIFO_WIDTH  = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SREG_RST  = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] DRIVE_OFF = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 10;
	localparam int CLK_TO_STROBE_NS     = 300;
	localparam int CLK_TO_STROBE_CYCLES = (CLK_TO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: logic/sld_rise_det.sv */
// Rising-edge detector for a synchronous level input
`timescale 1ns/1ps
module sld_rise_det (
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic nrst_in,
	// Level in, pulse out
	input  wire logic level_in,
	output logic      rise_out
);
	typedef struct packed {
		logic prev;
	} sld_rise_s;

	sld_rise_s q;
	sld_rise_s next_q;

	always_comb begin
		next_q      = q;
		next_q.prev = level_in;
	end

	// Prev resets high so a clock already high at release is no edge
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			q <= '{prev: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	assign rise_out = level_in && !q.prev;
endmodule // sld_rise_det

/* File: logic/sld_stream_if.sv */
// Valid/ready carrier between the bit queue and its users
`timescale 1ns/1ps
interface sld_stream_if #(
	parameter int WIDTH = 1
);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport queue (
		input  push_valid,
		output push_ready,
		input  push_data,
		output pop_valid,
		input  pop_ready,
		output pop_data
	);

	modport user (
		output push_valid,
		input  push_ready,
		output push_data,
		input  pop_valid,
		output pop_ready,
		input  pop_data
	);
endinterface

/* File: tb/sld_host_model.sv */
// Host model driving the serial control pins of the driver
`timescale 1ns/1ps
module sld_host_model (
	// Clock
	input  wire logic sys_clk_in,
	// Serial control pins
	output logic      serial_data_out,
	output logic      shift_clk_out,
	output logic      strobe_out,
	output logic      out_disable_out
);
	import sld_pkg::*;

	initial begin
		serial_data_out = 1'b0;
		shift_clk_out   = 1'b0;
		strobe_out      = 1'b0;
		out_disable_out = 1'b1;
	end

	// Data is inverted once its hold has run out
	task automatic shift_bit(input logic b);
		@(posedge sys_clk_in) #1;
		serial_data_out = b;
		shift_clk_out   = 1'b1;
		@(posedge sys_clk_in) #1;
		shift_clk_out   = 1'b0;
		serial_data_out = ~b;
	endtask

	// Last bit sent lands in the first stage
	task automatic shift_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			shift_bit(v[i]);
		end
	endtask

	task automatic pulse_strobe();
		repeat (CLK_TO_STROBE_CYCLES) @(posedge sys_clk_in);
		#1 strobe_out = 1'b1;
		@(posedge sys_clk_in) #1;
		strobe_out = 1'b0;
	endtask

	// Sets strobe to the given level and disables the outputs in the same step
	task automatic hold_strobe(input logic s);
		@(posedge sys_clk_in) #1;
		out_disable_out = 1'b1;
		strobe_out      = s;
	endtask

	task automatic set_disable(input logic d);
		@(posedge sys_clk_in) #1;
		out_disable_out = d;
	endtask
endmodule // sld_host_model

/* File: tb/test_sld_driver_top.sv */
// Self-checking bench of the serial-in latched driver
`timescale 1ns/1ps
module test_sld_driver_top;
	import sld_pkg::*;

	logic              sys_clk;
	logic              nrst;
	wire               sdat;
	wire               sclk;
	wire               strobe;
	wire               dis;
	logic              hold;
	wire  [STAGES-1:0] drive_out;
	wire               cascade_out;
	wire               ready_out;
	int                n_fail = 0;
	int                check_count = 0;
	logic [7:0]        row_data [4] = '{8'hA5, 8'hFF, 8'h81, 8'h3C};
	logic              row_dis  [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	logic [7:0]        row_exp  [4] = '{8'hA5, 8'h00, 8'h81, 8'h3C};
	logic              row_casc [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	sld_host_model host (
		.sys_clk_in      (sys_clk),
		.serial_data_out (sdat),
		.shift_clk_out   (sclk),
		.strobe_out      (strobe),
		.out_disable_out (dis)
	);

	sld_driver_top uut (
		.sys_clk_in      (sys_clk),
		.nrst_in         (nrst),
		.serial_data_in  (sdat),
		.shift_clk_in    (sclk),
		.strobe_in       (strobe),
		.out_disable_in  (dis),
		.shift_hold_in   (hold),
		.drive_out       (drive_out),
		.cascade_out     (cascade_out),
		.shift_ready_out (ready_out)
	);

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		int k;
		nrst = 1'b0;
		hold = 1'b0;
		settle(2);
		nrst = 1'b1;
		settle(1);
		check("drive_rst", drive_out, 8'h00);
		// ------------------------------------------------------------
		// Table of ordinary loads
		// ------------------------------------------------------------
		for (int i = 0; i < 4; i++) begin
			host.set_disable(row_dis[i]);
			host.shift_byte(row_data[i]);
			host.pulse_strobe();
			settle(3);
			check("drive", drive_out, row_exp[i]);
			check("cascade", {7'h00, cascade_out}, {7'h00, row_casc[i]});
		end
		// ------------------------------------------------------------
		// Hold with strobe low, blanking keeps the latch
		// ------------------------------------------------------------
		host.shift_byte(8'hC3);
		settle(6);
		check("drive_held", drive_out, 8'h3C);
		check("cascade_new", {7'h00, cascade_out}, 8'h01);
		host.set_disable(1'b1);
		settle(3);
		check("drive_off", drive_out, 8'h00);
		host.set_disable(1'b0);
		settle(3);
		check("drive_back", drive_out, 8'h3C);
		// ------------------------------------------------------------
		// Transparent latches follow the shifts
		// ------------------------------------------------------------
		host.hold_strobe(1'b1);
		host.shift_byte(8'h5A);
		host.set_disable(1'b0);
		settle(3);
		check("drive_transp", drive_out, 8'h5A);
		host.set_disable(1'b1);
		host.shift_bit(1'b1);
		host.set_disable(1'b0);
		settle(4);
		check("drive_follow", drive_out, 8'hB5);
		host.hold_strobe(1'b0);
		// ------------------------------------------------------------
		// Queue fill, dropped edges, drain
		// ------------------------------------------------------------
		hold = 1'b1;
		host.shift_byte(8'hFF);
		host.shift_byte(8'hFF);
		host.shift_byte(8'hFF);
		host.shift_byte(8'hFF);
		host.shift_byte(8'h00);
		check("ready_full", {7'h00, ready_out}, 8'h00);
		hold = 1'b0;
		k = 0;
		while (ready_out !== 1'b1 && k < 200) begin
			settle(1);
			k++;
		end
		if (k == 200) begin
			n_fail++;
			summarize();
		end
		host.set_disable(1'b0);
		host.pulse_strobe();
		settle(3);
		check("drive_drain", drive_out, 8'hFF);
		check("cascade_drain", {7'h00, cascade_out}, 8'h01);
		// ------------------------------------------------------------
		// Reset in mid-run
		// ------------------------------------------------------------
		nrst = 1'b0;
		settle(2);
		check("drive_rst2", drive_out, 8'h00);
		check("cascade_rst2", {7'h00, cascade_out}, 8'h00);
		nrst = 1'b1;
		host.shift_bit(1'b1);
		host.pulse_strobe();
		settle(3);
		check("drive_after_rst", drive_out, 8'h01);
		check("cascade_after_rst", {7'h00, cascade_out}, 8'h00);
		summarize();
	end
endmodule // test_sld_driver_top
